// File: hw/timing_controller.sv
// timing_controller: timer 1 divider for the timing-chip master clock,
// event counter, dma request routing, interrupt request assignment.
// assumes apb master on pclk, and timing-chip outputs/eop/timers 2-3 as pins.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ns

module timing_controller
    import timing_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic end_of_process,
    input wire logic end_of_process_mask_n,
    input wire logic timer0_event,
    input wire logic [4:0] timing_output_pins,
    input wire logic timer2_out,
    input wire logic timer3_out,
    output logic timing_chip_clock,
    output logic [7:0] dma_request_line_n,
    output logic [4:0] irq_request_n,
    output logic [1:0] board_sync_bus_timer,
    output logic timing_clock_valid,
    output logic irq
);

    // pin synchronisers: first stage only feeds second stage
    logic [7:0] pin_meta_reg;
    logic [7:0] pin_sync_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_reg <= 8'h00;
            pin_sync_reg <= 8'h00;
        end else begin
            pin_meta_reg <= {timer3_out, timer2_out, timer0_event, end_of_process_mask_n,
                             end_of_process, timing_output_pins[4:2]};
            pin_sync_reg <= pin_meta_reg;
        end
    end
    logic [2:0] tout_s;
    logic eop_s;
    logic eop_mask_n_s;
    logic ev_s;
    logic [1:0] t23_s;
    assign tout_s = pin_sync_reg[2:0];
    assign eop_s = pin_sync_reg[3];
    assign eop_mask_n_s = pin_sync_reg[4];
    assign ev_s = pin_sync_reg[5];
    assign t23_s = pin_sync_reg[7:6];

    // apb decode; this slave answers in the access cycle with no wait state
    logic acc;
    logic wr;
    logic rd;
    logic [21:0] word_addr;
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    assign word_addr = paddr[21:0];

    function automatic logic hit(input logic [31:0] a, input logic [21:0] target);
        hit = (a[31:22] == 10'h000) && (a[21:0] == target);
    endfunction : hit

    logic mapped;
    always_comb begin
        if (hit(paddr, timer1_divider_port_addr)) begin
            mapped = 1'b1;
        end else if (hit(paddr, timer_control_word_addr)) begin
            mapped = 1'b1;
        end else if (hit(paddr, board_control_register_addr)) begin
            mapped = 1'b1;
        end else if (hit(paddr, irq_status_addr)) begin
            mapped = 1'b1;
        end else if (hit(paddr, irq_mask_addr)) begin
            mapped = 1'b1;
        end else if (hit(paddr, timer_status_addr)) begin
            mapped = 1'b1;
        end else if (hit(paddr, timing_output_addr)) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    // control word register; only a word selecting counter 1 is kept
    logic [7:0] control_word_reg;
    logic cw_write;
    assign cw_write = wr && hit(paddr, timer_control_word_addr) &&
                      (pwdata[cw_sel_msb:cw_sel_lsb] == cw_sel_counter1);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_word_reg <= 8'h00;
        end else if (cw_write) begin
            control_word_reg <= pwdata[7:0];
        end
    end

    // divider load sequence: low byte then high byte, then counting starts
    load_state_type load_state_reg;
    logic [7:0] low_byte_reg;
    logic [15:0] divider_reg;
    logic div_write;
    logic div_read;
    logic load_done;
    assign div_write = wr && hit(paddr, timer1_divider_port_addr);
    assign div_read = rd && hit(paddr, timer1_divider_port_addr);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_state_reg <= load_idle;
        end else if (cw_write) begin
            load_state_reg <= load_wait_low; // new control word stops the counter
        end else if (div_write) begin
            case (load_state_reg)
                load_wait_low: load_state_reg <= load_wait_high;
                load_wait_high: load_state_reg <= load_running;
                load_running: load_state_reg <= load_wait_high; // reload restarts sequence
                default: load_state_reg <= load_idle;
            endcase
        end
    end
    assign load_done = div_write && (load_state_reg == load_wait_high);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_byte_reg <= 8'h00;
            divider_reg <= divider_reset;
        end else if (div_write && load_state_reg != load_wait_high) begin
            low_byte_reg <= pwdata[7:0];
        end else if (load_done) begin
            divider_reg <= {pwdata[7:0], low_byte_reg};
        end
    end

    // read-back toggles low/high byte of the live count
    logic read_high_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_high_reg <= 1'b0;
        end else if (cw_write) begin
            read_high_reg <= 1'b0;
        end else if (div_read) begin
            read_high_reg <= !read_high_reg;
        end
    end

    // mode 3 square wave: count down by one from each half length, toggle output at each half period.
    // odd dividers get the extra cycle in the high half, so high is about half.
    logic [15:0] count_reg;
    logic half_reg;
    logic running;
    logic [16:0] full_div;
    logic [15:0] half_len;
    logic wrap_pulse;
    assign running = (load_state_reg == load_running) &&
                     (control_word_reg[cw_mode_msb:cw_mode_lsb] == cw_mode_square);
    assign full_div = (divider_reg == 16'h0000) ? 17'h10000 : {1'b0, divider_reg};
    assign half_len = half_reg ? full_div[16:1] : 16'(full_div[16:1] + {15'h0000, full_div[0]});
    assign wrap_pulse = running && (count_reg <= 16'h0001) && !half_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= 16'h0000;
            half_reg <= 1'b0;
            timing_chip_clock <= 1'b1;
        end else if (load_done) begin
            count_reg <= 16'h0000;
            half_reg <= 1'b1;
            timing_chip_clock <= 1'b1;
        end else if (running) begin
            if (count_reg <= 16'h0001) begin
                count_reg <= half_len;
                half_reg <= !half_reg;
                timing_chip_clock <= !half_reg;
            end else begin
                count_reg <= count_reg - 16'h0001;
            end
        end else begin
            timing_chip_clock <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timing_clock_valid <= 1'b0;
        end else begin
            timing_clock_valid <= running;
        end
    end

    // timer 0: event counter only, no pin driven
    logic [15:0] event_count_reg;
    logic ev_d_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_count_reg <= event_count_reset;
            ev_d_reg <= 1'b0;
        end else begin
            ev_d_reg <= ev_s;
            if (ev_s && !ev_d_reg) begin
                event_count_reg <= event_count_reg + 16'h0001;
            end
        end
    end

    // board control register: dma routing enables
    logic [2:0] board_control_register_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            board_control_register_reg <= bcr_reset;
        end else if (wr && hit(paddr, board_control_register_addr)) begin
            board_control_register_reg <= pwdata[2:0];
        end
    end

    // dma request lines are active low; unrouted lines stay inactive
    logic [7:0] dma_next;
    always_comb begin
        dma_next = 8'hff;
        if (board_control_register_reg[bcr_timing_output_two_bit]) begin
            dma_next[dma_line_timing_output_two] = !tout_s[0];
        end
        if (board_control_register_reg[bcr_timing_output_three_bit]) begin
            dma_next[dma_line_timing_output_three] = !tout_s[1];
        end
        if (board_control_register_reg[bcr_timing_output_four_bit]) begin
            dma_next[dma_line_timing_output_four] = !tout_s[2];
        end
    end

    // interrupt request pins: 11 is masked eop, 12..15 held inactive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dma_request_line_n <= 8'hff;
            irq_request_n <= irq_unused_high;
            board_sync_bus_timer <= 2'h0;
        end else begin
            dma_request_line_n <= dma_next;
            irq_request_n[0] <= !(eop_s && eop_mask_n_s);
            irq_request_n[4:1] <= irq_unused_high[4:1];
            board_sync_bus_timer <= t23_s;
        end
    end

    // sticky status; a set in the clearing cycle wins over the clear
    logic [2:0] irq_status_reg;
    logic [2:0] irq_mask_reg;
    logic [2:0] irq_set;
    logic eop_d_reg;
    logic valid_d_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eop_d_reg <= 1'b0;
            valid_d_reg <= 1'b0;
        end else begin
            eop_d_reg <= eop_s;
            valid_d_reg <= running;
        end
    end
    always_comb begin
        irq_set = 3'h0;
        irq_set[irq_eop_bit] = eop_s && !eop_d_reg;
        irq_set[irq_valid_bit] = running && !valid_d_reg;
        irq_set[irq_wrap_bit] = wrap_pulse;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_reg <= irq_reset;
        end else if (wr && hit(paddr, irq_status_addr)) begin
            irq_status_reg <= (irq_status_reg & ~pwdata[2:0]) | irq_set;
        end else begin
            irq_status_reg <= irq_status_reg | irq_set;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_reg <= irq_reset;
        end else if (wr && hit(paddr, irq_mask_addr)) begin
            irq_mask_reg <= pwdata[2:0];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |((irq_status_reg | irq_set) & irq_mask_reg);
        end
    end

    // read mux; control word is write-only and reads zero
    logic [31:0] rdata_next;
    always_comb begin
        rdata_next = 32'h00000000;
        if (word_addr == timer1_divider_port_addr) begin
            rdata_next[7:0] = read_high_reg ? count_reg[15:8] : count_reg[7:0];
        end else if (word_addr == board_control_register_addr) begin
            rdata_next[2:0] = board_control_register_reg;
        end else if (word_addr == irq_status_addr) begin
            rdata_next[2:0] = irq_status_reg;
        end else if (word_addr == irq_mask_addr) begin
            rdata_next[2:0] = irq_mask_reg;
        end else if (word_addr == timer_status_addr) begin
            rdata_next = {load_state_reg, 14'h0000, event_count_reg};
        end else if (word_addr == timing_output_addr) begin
            rdata_next[2:0] = tout_s;
        end
    end

    // registered answer: ready in the first access cycle, so pready comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= (psel && !penable && !pwrite && mapped) ? rdata_next : 32'h00000000;
        end
    end

endmodule : timing_controller

// File: hw/timing_pkg.sv
// timing_pkg: register map, field positions, reset values and mode codes
// for the system timing block. assumes an APB slave with 32-bit data.
package timing_pkg;
    // timer map offsets are register indices; the byte address is four times the index
    localparam logic [19:0] timer1_divider_port_index = 20'h80041;
    localparam logic [19:0] timer_control_word_index = 20'h90041;
    localparam logic [21:0] timer1_divider_port_addr = {timer1_divider_port_index, 2'b00};
    localparam logic [21:0] timer_control_word_addr = {timer_control_word_index, 2'b00};
    // block-local registers, placed above the timer map
    localparam logic [21:0] board_control_register_addr = 22'h300000;
    localparam logic [21:0] irq_status_addr = 22'h300004;
    localparam logic [21:0] irq_mask_addr = 22'h300008;
    localparam logic [21:0] timer_status_addr = 22'h30000c;
    localparam logic [21:0] timing_output_addr = 22'h300010;
    // control word fields
    localparam int cw_sel_msb = 7;
    localparam int cw_sel_lsb = 6;
    localparam int cw_rw_msb = 5;
    localparam int cw_rw_lsb = 4;
    localparam int cw_mode_msb = 3;
    localparam int cw_mode_lsb = 1;
    localparam int cw_bcd_bit = 0;
    localparam logic [1:0] cw_sel_counter1 = 2'h1;
    localparam logic [1:0] cw_rw_low_high = 2'h3;
    localparam logic [2:0] cw_mode_square = 3'h3;
    localparam logic [7:0] cw_setup_value = 8'h76;
    // board control register bits: route timing outputs onto dma lines
    localparam int bcr_timing_output_two_bit = 0;
    localparam int bcr_timing_output_three_bit = 1;
    localparam int bcr_timing_output_four_bit = 2;
    localparam logic [2:0] bcr_reset = 3'h0;
    // dma request line numbers fed by timing outputs two, three, four
    localparam int dma_line_timing_output_two = 5;
    localparam int dma_line_timing_output_three = 0;
    localparam int dma_line_timing_output_four = 6;
    // interrupt status bits
    localparam int irq_eop_bit = 0;
    localparam int irq_valid_bit = 1;
    localparam int irq_wrap_bit = 2;
    localparam logic [2:0] irq_reset = 3'h0;
    localparam logic [15:0] divider_reset = 16'h0000;
    localparam logic [15:0] event_count_reset = 16'h0000;
    localparam logic [4:0] irq_unused_high = 5'h1f;
    typedef enum logic [1:0] {
        load_idle = 2'b00,
        load_wait_low = 2'b01,
        load_wait_high = 2'b10,
        load_running = 2'b11
    } load_state_type;
endpackage : timing_pkg

// File: test/timing_controller_properties.sv
// timing_controller_properties: port checks for the timing controller.
// bound into the design by the bench; it sees only top-level ports.
`timescale 1ns/1ns
module timing_controller_properties
    import timing_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic end_of_process,
    input wire logic end_of_process_mask_n,
    input wire logic [4:0] timing_output_pins,
    input wire logic timer2_out,
    input wire logic timing_chip_clock,
    input wire logic [7:0] dma_request_line_n,
    input wire logic [4:0] irq_request_n,
    input wire logic [1:0] board_sync_bus_timer,
    input wire logic timing_clock_valid
);
    logic wr_go;
    logic cw_ok_reg;
    logic byte_hi_reg;
    logic div_done_reg;
    logic [7:0] low_reg;
    logic [15:0] div_reg;
    logic [2:0] route_reg;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    assign wr_go = psel && penable && pready && pwrite;
    // shadow copies of route enables and divider bytes, as internals are hidden
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cw_ok_reg <= 1'b0;
            byte_hi_reg <= 1'b0;
            div_done_reg <= 1'b0;
            low_reg <= 8'h00;
            div_reg <= 16'h0000;
            route_reg <= 3'h0;
        end else begin
            div_done_reg <= 1'b0;
            if (wr_go && paddr == {10'h000, board_control_register_addr}) begin
                route_reg <= pwdata[2:0];
            end
            // a control word for another counter is ignored by the device
            if (wr_go && paddr == {10'h000, timer_control_word_addr} && pwdata[7:6] == 2'h1) begin
                cw_ok_reg <= pwdata[7:0] == 8'h76;
                byte_hi_reg <= 1'b0;
            end
            if (wr_go && paddr == {10'h000, timer1_divider_port_addr}) begin
                byte_hi_reg <= !byte_hi_reg;
                low_reg <= pwdata[7:0];
                if (byte_hi_reg) begin
                    div_reg <= {pwdata[7:0], low_reg};
                    div_done_reg <= cw_ok_reg;
                end
            end
        end
    end
    chk_irq_eop_on: assert property ((end_of_process && end_of_process_mask_n) [*4]
        |-> !irq_request_n[0]) else $error("irq 11 idle while eop passes");
    chk_irq_eop_off: assert property ((!end_of_process) [*4] |-> irq_request_n[0])
        else $error("irq 11 active without eop");
    chk_irq_unused: assert property (irq_request_n[4:1] == 4'hf)
        else $error("unused irq input driven low");
    chk_sync_timer2: assert property (timer2_out [*4] |-> board_sync_bus_timer[0])
        else $error("timer 2 not on sync bus");
    chk_dma_route_on: assert property ((route_reg[0] && timing_output_pins[2]) [*4]
        |-> !dma_request_line_n[5]) else $error("output two not on dma line 5");
    chk_dma_route_off: assert property ((!route_reg[2]) [*2] |-> dma_request_line_n[6])
        else $error("dma line 6 active while disabled");
    chk_dma_spare: assert property (dma_request_line_n[4:1] == 4'hf && dma_request_line_n[7])
        else $error("unrouted dma line active");
    chk_clock_start: assert property (div_done_reg |-> ##[1:3] timing_clock_valid)
        else $error("clock not valid after divider");
    chk_clock_idle: assert property ((!timing_clock_valid) [*3] |-> timing_chip_clock)
        else $error("chip clock moves while idle");
    chk_clock_square: assert property ($fell(timing_chip_clock) && timing_clock_valid
        && div_reg == 16'h000a && $past(timing_clock_valid, 8) && $past(timing_clock_valid, 6)
        |-> $past(timing_chip_clock, 5) && !$past(timing_chip_clock, 6))
        else $error("high phase not five cycles");
    chk_apb_pulse: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not a one-cycle answer");
endmodule : timing_controller_properties

// File: test/timing_chip_model.sv
// timing_chip_model: behavioural far-side counter chip for the bench.
// its outputs move only on master clock edges, so nothing moves before setup.
`timescale 1ns/1ns
module timing_chip_model (
    input wire logic master_clock,
    input wire logic presetn,
    input wire logic [4:0] load_pattern,
    output logic [4:0] counter_outputs
);
    // five counter outputs, updated from the bench pattern per master tick
    always_ff @(posedge master_clock or negedge presetn) begin
        if (!presetn) begin
            counter_outputs <= 5'h00;
        end else begin
            counter_outputs <= load_pattern;
        end
    end
endmodule : timing_chip_model

// File: test/timing_controller_bench.sv
// timing_controller_bench: self-checking bench for the timing controller.
// assumes the design, its package, the checker and the chip model are compiled.
`timescale 1ns/1ns
module timing_controller_bench
    import timing_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, q, r;
    logic end_of_process = 1'b0, end_of_process_mask_n = 1'b0, timer0_event = 1'b0;
    logic timer2_out = 1'b0, timer3_out = 1'b0, pready, pslverr, e;
    logic timing_chip_clock, timing_clock_valid, irq;
    logic [4:0] timing_output_pins, irq_request_n, pattern = 5'h00;
    logic [7:0] dma_request_line_n;
    logic [1:0] board_sync_bus_timer;
    logic [31:0] seed = 32'h00001442;
    int n_mismatch = 0, check_count = 0, cyc = 0;
    timing_controller uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .end_of_process(end_of_process),
        .end_of_process_mask_n(end_of_process_mask_n), .timer0_event(timer0_event),
        .timing_output_pins(timing_output_pins), .timer2_out(timer2_out),
        .timer3_out(timer3_out), .timing_chip_clock(timing_chip_clock),
        .dma_request_line_n(dma_request_line_n), .irq_request_n(irq_request_n),
        .board_sync_bus_timer(board_sync_bus_timer),
        .timing_clock_valid(timing_clock_valid), .irq(irq));
    timing_chip_model far (.master_clock(timing_chip_clock), .presetn(presetn),
        .load_pattern(pattern), .counter_outputs(timing_output_pins));
    always #50 pclk = ~pclk;
    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        rnd = seed;
    endfunction : rnd
    function automatic logic [7:0] dma_exp(input logic [2:0] b, input logic [4:0] p);
        dma_exp = 8'hff;
        dma_exp[5] = !(b[0] && p[2]);
        dma_exp[0] = !(b[1] && p[3]);
        dma_exp[6] = !(b[2] && p[4]);
    endfunction : dma_exp
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        check_count++;
        if (got !== ex) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    // one apb transfer; read data and error are taken at the pready edge
    task automatic apb(input logic dir, input logic [21:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= dir;
        paddr <= {10'h000, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n == 16) chk("pready", 32'h1, 32'h0);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [21:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input string nm, input logic [21:0] a, input logic [31:0] ex, input logic ee);
        apb(1'b0, a, 32'h0);
        chk(nm, ex, q);
        chk("slverr", {31'h0, ee}, {31'h0, e});
    endtask : rd
    // program counter 1 and measure one full period of the chip clock
    task automatic run_div(input logic [15:0] dv);
        int n;
        int lo;
        int hi;
        wr(timer_control_word_addr, 32'h76);
        wr(timer1_divider_port_addr, {24'h0, dv[7:0]});
        wr(timer1_divider_port_addr, {24'h0, dv[15:8]});
        n = 0;
        while (timing_clock_valid !== 1'b1 && n < 8) begin
            tick(1);
            n++;
        end
        chk("clock valid", 32'h1, {31'h0, timing_clock_valid});
        n = 0;
        while (timing_chip_clock !== 1'b0 && n < 200) begin
            tick(1);
            n++;
        end
        lo = 0;
        while (timing_chip_clock === 1'b0 && lo < 200) begin
            tick(1);
            lo++;
        end
        hi = 0;
        while (timing_chip_clock === 1'b1 && hi < 200) begin
            tick(1);
            hi++;
        end
        chk("low cycles", 32'(dv / 2), 32'(lo));
        chk("high cycles", 32'((dv + 1) / 2), 32'(hi));
    endtask : run_div
    task give_verdict();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    initial begin
        int k;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        tick(1);
        chk("irq lines", 32'h1f, {27'h0, irq_request_n});
        chk("dma lines", 32'hff, {24'h0, dma_request_line_n});
        chk("chip clock", 32'h1, {31'h0, timing_chip_clock});
        rd("control word", timer_control_word_addr, 32'h0, 1'b0);
        rd("board control", board_control_register_addr, 32'h0, 1'b0);
        rd("unmapped", 22'h300020, 32'h0, 1'b1);
        $display("test reset done");
        // every eop and mask combination onto irq input 11
        for (k = 0; k < 4; k++) begin
            end_of_process <= k[0];
            end_of_process_mask_n <= k[1];
            tick(5);
            chk("irq lines", {27'h0, 4'hf, !(k[0] && k[1])}, {27'h0, irq_request_n});
        end
        rd("irq status", irq_status_addr, 32'h1, 1'b0);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(irq_mask_addr, 32'h1);
        tick(2);
        chk("irq raised", 32'h1, {31'h0, irq});
        end_of_process <= 1'b0;
        tick(4);
        wr(irq_status_addr, 32'h1);
        tick(2);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rd("irq status", irq_status_addr, 32'h0, 1'b0);
        wr(irq_mask_addr, 32'h0);
        $display("test eop and irq done");
        run_div(16'h000a);
        for (k = 0; k < 4; k++) run_div(16'h0002 + 16'(rnd() % 30));
        rd("irq status", irq_status_addr, 32'h6, 1'b0);
        $display("test clock setup done");
        // first pass enables every route with all outputs high
        for (k = 0; k < 6; k++) begin
            r = (k == 0) ? 32'h3ff : rnd();
            pattern <= r[7:3];
            timer2_out <= r[8];
            timer3_out <= r[9];
            wr(board_control_register_addr, {29'h0, r[2:0]});
            tick(70);
            chk("dma lines", {24'h0, dma_exp(r[2:0], r[7:3])}, {24'h0, dma_request_line_n});
            chk("sync bus", {30'h0, r[9:8]}, {30'h0, board_sync_bus_timer});
            rd("timing outputs", timing_output_addr, {29'h0, r[7:5]}, 1'b0);
        end
        $display("test routing done");
        for (k = 0; k < 7; k++) begin
            timer0_event <= 1'b1;
            tick(3);
            timer0_event <= 1'b0;
            tick(3);
        end
        apb(1'b0, timer_status_addr, 32'h0);
        chk("event count", 32'h7, {16'h0, q[15:0]});
        wr(timer_control_word_addr, 32'h36);
        tick(4);
        chk("select ignored", 32'h1, {31'h0, timing_clock_valid});
        wr(timer_control_word_addr, 32'h72);
        tick(4);
        chk("stopped", 32'h1, {31'h0, timing_chip_clock && !timing_clock_valid});
        $display("test events and stop done");
        give_verdict();
    end
endmodule : timing_controller_bench
bind timing_controller timing_controller_properties chk_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .end_of_process(end_of_process),
    .end_of_process_mask_n(end_of_process_mask_n), .timing_output_pins(timing_output_pins),
    .timer2_out(timer2_out), .timing_chip_clock(timing_chip_clock),
    .dma_request_line_n(dma_request_line_n), .irq_request_n(irq_request_n),
    .board_sync_bus_timer(board_sync_bus_timer), .timing_clock_valid(timing_clock_valid));
